// >>> pps_sequencer.sv
// push-pull driver sequencer: modes, soft-start, protection, gate drive
// assumes comparator results and the external clock are asynchronous levels
//
// Contract
// - per-switch cycle-by-cycle current limit ends conduction
// - current guard ignored during soft-start
// - soft short: drive off 100 ns, retry
// - retries repeat each on-time, both off
// - dip over 2.5 V: hard short, 5 A
// - hard short over 200 us reruns soft-start
// - react to hard short within 65 ns
// - enable low keeps shutdown, no switching
// - enabled but supply low: outputs inactive
// - switch only with supply and enable up
// - 5 us glitch filter on enable
// - floating enable reads as disabled
// - over-temperature stops switching at once
// - thermal restart only below lower threshold
// - oscillator starts when supply and enable up
// - soft-start ramps drive on power-up, enable
// - operation mode after soft-start, fixed frequency
// - disabled or low supply: drains high-impedance
// - sync mode divides external clock by two
// - sync mode sticks; lost clock halts switching
// - sync mode disables duty control, spreading
// - complementary drives with 70 ns dead time
// - overvoltage stops after 550 ns, hysteresis
`timescale 1ns/100ps
module pps_sequencer #(
    parameter int HARD_LONG_CYC = pps_pkg::HARD_LONG_CYC,
    parameter int SS_STEP_CYC   = pps_pkg::SS_STEP_CYC
) (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    // comparator results, asynchronous
    input  wire logic       EN_ABOVE,
    input  wire logic       SUPPLY_OK,
    input  wire logic       OC_TRIP,
    input  wire logic       HARD_TRIP,
    input  wire logic       DIP_HARD,
    input  wire logic       TEMP_HOT,
    input  wire logic       TEMP_COOL,
    input  wire logic       OV_RISE,
    input  wire logic       OV_CLEAR,
    // external sync clock
    input  wire logic       EXT_CLK,
    // switch drives
    output logic            GATE_A,
    output logic            GATE_B,
    output logic            DRAIN_A_O,
    output logic            DRAIN_A_OE,
    output logic            DRAIN_B_O,
    output logic            DRAIN_B_OE,
    output logic [7:0]      GATE_STRENGTH,
    output logic            SS_DISCHARGE,
    // status and mode
    output logic [5:0]      MODE,
    output logic            OSC_RUN,
    output logic            SYNC_MODE,
    output logic            DUTY_CTRL_EN,
    output logic            SPREAD_EN
);
    localparam int W = pps_pkg::CNT_W;

    logic [9:0]             sync1_ff;
    logic [9:0]             sync2_ff;
    logic                   en_s, sup_s, oc_s, hard_s, dip_s;
    logic                   hot_s, cool_s, ovr_s, ovc_s, ext_s;
    logic                   ext_prev_ff;
    logic                   ext_rise;
    pps_pkg::pps_state_e    state_ff, nxt_state;
    logic                   en_filt_ff;
    logic [W-1:0]           glitch_cnt_ff;
    logic                   tsd_ff;
    logic [W-1:0]           ov_cnt_ff;
    logic                   ov_stop_ff;
    logic                   ext_mode_ff;
    logic [W-1:0]           ext_idle_ff;
    logic                   ext_lost;
    logic [W-1:0]           osc_cnt_ff;
    logic                   phase_ff;
    logic                   tick;
    logic [3:0]             dead_ff;
    logic [3:0]             retry_ff;
    logic                   cut_ff;
    logic                   gate_a_ff, gate_b_ff;
    logic [7:0]             ss_lvl_ff;
    logic [W-1:0]           step_ff;
    logic [W-1:0]           hard_cnt_ff;
    logic                   hard_long;
    logic                   switching, conducting, oc_en;
    logic                   trip_soft, trip_hard;

    function automatic logic hit(input logic [W-1:0] cnt, input int lim);
        hit = (cnt == W'(lim - 1));
    endfunction : hit

    // two-flop synchronisers; reset to zero so a floating enable reads off
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            sync1_ff <= 10'h000;
            sync2_ff <= 10'h000;
        end else begin
            sync1_ff <= {EXT_CLK, OV_CLEAR, OV_RISE, TEMP_COOL, TEMP_HOT,
                         DIP_HARD, HARD_TRIP, OC_TRIP, SUPPLY_OK, EN_ABOVE};
            sync2_ff <= sync1_ff;
        end
    end
    assign {ext_s, ovc_s, ovr_s, cool_s, hot_s, dip_s, hard_s, oc_s, sup_s, en_s} = sync2_ff;
    assign ext_rise = ext_s & ~ext_prev_ff;

    // enable glitch filter: input must differ for the full window to flip
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            en_filt_ff    <= 1'b0;
            glitch_cnt_ff <= '0;
        end else if (en_s == en_filt_ff) begin
            glitch_cnt_ff <= '0;
        end else if (hit(glitch_cnt_ff, pps_pkg::GLITCH_CYC)) begin
            en_filt_ff    <= en_s;
            glitch_cnt_ff <= '0;
        end else begin
            glitch_cnt_ff <= glitch_cnt_ff + W'(1);
        end
    end

    // thermal latch with hysteresis, overvoltage stop after its delay
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            tsd_ff     <= 1'b0;
            ov_stop_ff <= 1'b0;
            ov_cnt_ff  <= '0;
        end else begin
            if (hot_s)
                tsd_ff <= 1'b1;
            else if (cool_s)
                tsd_ff <= 1'b0;
            ov_cnt_ff <= ovr_s && !hit(ov_cnt_ff, pps_pkg::OV_CYC) ? ov_cnt_ff + W'(1) : '0;
            if (ovr_s && hit(ov_cnt_ff, pps_pkg::OV_CYC))
                ov_stop_ff <= 1'b1;
            else if (ovc_s && !ovr_s)
                ov_stop_ff <= 1'b0;
        end
    end

    // sync mode is chosen before switching starts and only reset leaves it
    assign ext_lost = ext_mode_ff & hit(ext_idle_ff, pps_pkg::EXT_LOSS_CYC);
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ext_prev_ff <= 1'b0;
            ext_mode_ff <= 1'b0;
            ext_idle_ff <= '0;
        end else begin
            ext_prev_ff <= ext_s;
            if (ext_rise && (state_ff == pps_pkg::ST_OFF || state_ff == pps_pkg::ST_WAIT))
                ext_mode_ff <= 1'b1;
            if (ext_rise || !ext_mode_ff)
                ext_idle_ff <= '0;
            else if (!ext_lost)
                ext_idle_ff <= ext_idle_ff + W'(1);
        end
    end

    // persistent hard short timer
    assign hard_long = hit(hard_cnt_ff, HARD_LONG_CYC);
    always_ff @(posedge CLK) begin
        if (!RESET_N)
            hard_cnt_ff <= '0;
        else if (!dip_s || state_ff != pps_pkg::ST_RUN)
            hard_cnt_ff <= '0;
        else if (!hard_long)
            hard_cnt_ff <= hard_cnt_ff + W'(1);
    end

    // mode state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pps_pkg::ST_OFF: begin
                if (en_filt_ff)
                    nxt_state = pps_pkg::ST_WAIT;
            end
            pps_pkg::ST_WAIT: begin
                if (!en_filt_ff)
                    nxt_state = pps_pkg::ST_OFF;
                else if (sup_s)
                    nxt_state = pps_pkg::ST_SOFT;
            end
            pps_pkg::ST_SOFT, pps_pkg::ST_RUN: begin
                if (!en_filt_ff)
                    nxt_state = pps_pkg::ST_OFF;
                else if (!sup_s)
                    nxt_state = pps_pkg::ST_WAIT;
                else if (ext_lost)
                    nxt_state = pps_pkg::ST_HALT;
                else if (hard_long)
                    nxt_state = pps_pkg::ST_DISCH;
                else if (state_ff == pps_pkg::ST_SOFT && ss_lvl_ff == pps_pkg::SS_FULL)
                    nxt_state = pps_pkg::ST_RUN;
            end
            pps_pkg::ST_DISCH: begin
                if (!en_filt_ff)
                    nxt_state = pps_pkg::ST_OFF;
                else if (!dip_s && !hard_s)
                    nxt_state = pps_pkg::ST_WAIT;
            end
            pps_pkg::ST_HALT: nxt_state = pps_pkg::ST_HALT;
            default:          nxt_state = pps_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N)
            state_ff <= pps_pkg::ST_OFF;
        else
            state_ff <= nxt_state;
    end

    // soft-start ramp of gate strength; held at full in operation mode, at zero in the other modes
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ss_lvl_ff <= 8'h00;
            step_ff   <= '0;
        end else if (state_ff == pps_pkg::ST_RUN) begin
            ss_lvl_ff <= pps_pkg::SS_FULL;
            step_ff   <= '0;
        end else if (state_ff != pps_pkg::ST_SOFT) begin
            ss_lvl_ff <= 8'h00;
            step_ff   <= '0;
        end else if (hit(step_ff, SS_STEP_CYC)) begin
            step_ff   <= '0;
            if (ss_lvl_ff != pps_pkg::SS_FULL)
                ss_lvl_ff <= ss_lvl_ff + 8'h01;
        end else begin
            step_ff   <= step_ff + W'(1);
        end
    end

    // phase source: internal oscillator or external clock halved
    assign switching = (state_ff == pps_pkg::ST_SOFT || state_ff == pps_pkg::ST_RUN)
                       && !tsd_ff && !ov_stop_ff && !ext_lost;
    assign tick = ext_mode_ff ? ext_rise : hit(osc_cnt_ff, pps_pkg::INT_HALF_CYC);
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            osc_cnt_ff <= '0;
            phase_ff   <= 1'b0;
        end else begin
            if (!OSC_RUN || tick || ext_mode_ff)
                osc_cnt_ff <= '0;
            else
                osc_cnt_ff <= osc_cnt_ff + W'(1);
            if (OSC_RUN && tick)
                phase_ff <= ~phase_ff;
        end
    end

    // current guard: only after soft-start, per conducting switch
    assign conducting = gate_a_ff | gate_b_ff;
    assign oc_en      = (state_ff == pps_pkg::ST_RUN);
    assign trip_soft  = oc_en & conducting & ~dip_s & oc_s;
    assign trip_hard  = oc_en & dip_s & hard_s;

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            dead_ff  <= 4'h0;
            retry_ff <= 4'h0;
            cut_ff   <= 1'b0;
        end else begin
            if (tick)
                dead_ff <= 4'(pps_pkg::DEAD_CYC);
            else if (dead_ff != 4'h0)
                dead_ff <= dead_ff - 4'h1;
            if (trip_soft)
                retry_ff <= 4'(pps_pkg::RETRY_CYC);
            else if (retry_ff != 4'h0)
                retry_ff <= retry_ff - 4'h1;
            if (trip_hard && conducting)
                cut_ff <= 1'b1;
            else if (tick || !switching)
                cut_ff <= 1'b0;
        end
    end

    // gates follow the phase once dead time and any pause have elapsed
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            gate_a_ff <= 1'b0;
            gate_b_ff <= 1'b0;
        end else begin
            gate_a_ff <= switching && !phase_ff && dead_ff == 4'h0 && retry_ff == 4'h0
                         && !trip_soft && !cut_ff && !tick;
            gate_b_ff <= switching && phase_ff && dead_ff == 4'h0 && retry_ff == 4'h0
                         && !trip_soft && !cut_ff && !tick;
        end
    end

    // hard trip masks the gates directly: a register stage would miss the budget
    // stopping also masks them, since the gate registers lag the state by a cycle
    assign GATE_A        = gate_a_ff & ~trip_hard & switching;
    assign GATE_B        = gate_b_ff & ~trip_hard & switching;
    assign DRAIN_A_O     = 1'b0;
    assign DRAIN_B_O     = 1'b0;
    assign DRAIN_A_OE    = GATE_A;
    assign DRAIN_B_OE    = GATE_B;
    assign GATE_STRENGTH = ss_lvl_ff;
    assign SS_DISCHARGE  = (state_ff == pps_pkg::ST_DISCH);
    assign MODE          = state_ff;
    assign OSC_RUN       = switching;
    assign SYNC_MODE     = ext_mode_ff;
    assign DUTY_CTRL_EN  = ~ext_mode_ff;
    assign SPREAD_EN     = ~ext_mode_ff & switching;

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    localparam int RC = pps_pkg::RETRY_CYC;

    sequence s_both_off;
        !gate_a_ff && !gate_b_ff;
    endsequence
    sequence s_pause;
        s_both_off [*4];
    endsequence

    a_dead_gap: assert property ($rose(gate_a_ff) |->
        !$past(gate_b_ff, 1) && !$past(gate_b_ff, 2) && !$past(gate_b_ff, 3))
        else $error("gate A rose without full dead time");
    a_retry_pause: assert property (trip_soft |=> s_pause)
        else $error("retry pause shorter than 100 ns");
    a_soft_no_oc: assert property (state_ff == pps_pkg::ST_SOFT |-> !trip_soft && !cut_ff)
        else $error("current guard active during soft-start");
    a_hard_resp: assert property (hard_s && dip_s && state_ff == pps_pkg::ST_RUN
        |-> !GATE_A && !GATE_B)
        else $error("gates on during hard short");
    a_shutdown_hold: assert property (!en_filt_ff |=> state_ff == pps_pkg::ST_OFF
        || state_ff == pps_pkg::ST_HALT)
        else $error("left shutdown while disabled");
    a_off_hiz: assert property (state_ff inside {pps_pkg::ST_OFF, pps_pkg::ST_WAIT}
        |-> !DRAIN_A_OE && !DRAIN_B_OE)
        else $error("drain driven while disabled");
    a_tsd_stop: assert property (tsd_ff |=> !gate_a_ff && !gate_b_ff)
        else $error("switching during thermal shutdown");
    a_glitch_win: assert property ($changed(en_filt_ff)
        |-> $past(glitch_cnt_ff) == W'(pps_pkg::GLITCH_CYC - 1))
        else $error("enable changed before filter window");
    a_sync_sticky: assert property (ext_mode_ff |=> ext_mode_ff)
        else $error("left sync mode without reset");
    a_ov_delay: assert property ($rose(ov_stop_ff)
        |-> $past(ov_cnt_ff) == W'(pps_pkg::OV_CYC - 1))
        else $error("overvoltage stop timing wrong");
    a_run_after_ss: assert property (state_ff == pps_pkg::ST_SOFT && nxt_state == pps_pkg::ST_RUN
        |-> ss_lvl_ff == pps_pkg::SS_FULL)
        else $error("operation mode before ramp end");
    a_retry_len: assert property ($fell(retry_ff == 4'h0) |-> retry_ff == 4'(RC))
        else $error("retry counter loaded wrong");
endmodule : pps_sequencer

// >>> pps_pkg.sv
// constants and state codes for the push-pull protection and mode sequencer
// assumes one 40 MHz clock; analog comparator results arrive as logic levels
package pps_pkg;
    localparam int CLK_NS        = 25;
    localparam int CNT_W         = 16;
    // break-before-make gap, least time, rounded up
    localparam int DEAD_NS       = 70;
    localparam int DEAD_CYC      = (DEAD_NS + CLK_NS - 1) / CLK_NS;
    // hiccup pause after a soft-short trip, least time, rounded up
    localparam int RETRY_NS      = 100;
    localparam int RETRY_CYC     = (RETRY_NS + CLK_NS - 1) / CLK_NS;
    // hard-short reaction budget, longest time, rounded down
    localparam int HARD_RESP_NS  = 65;
    localparam int HARD_RESP_CYC = HARD_RESP_NS / CLK_NS;
    // overvoltage stop delay, longest time, rounded down
    localparam int OV_NS         = 550;
    localparam int OV_CYC        = OV_NS / CLK_NS;
    // enable glitch filter
    localparam int GLITCH_US     = 5;
    localparam int GLITCH_CYC    = GLITCH_US * 1000 / CLK_NS;
    // persistent hard short before a full soft-start rerun
    localparam int HARD_LONG_US  = 200;
    localparam int HARD_LONG_CYC = HARD_LONG_US * 1000 / CLK_NS;
    // internal oscillator half period (one gate phase)
    localparam int INT_HALF_CYC  = 20;
    // external clock counted as lost after this many idle cycles
    localparam int EXT_LOSS_CYC  = 400;
    // soft-start ramp: cycles per strength step, 255 steps from zero to full
    localparam int SS_STEP_CYC   = 312;
    localparam logic [7:0] SS_FULL = 8'hff;

    typedef enum logic [5:0] {
        ST_OFF   = 6'h01,
        ST_WAIT  = 6'h02,
        ST_SOFT  = 6'h04,
        ST_RUN   = 6'h08,
        ST_DISCH = 6'h10,
        ST_HALT  = 6'h20
    } pps_state_e;
endpackage : pps_pkg

// >>> pps_stage_model.sv
// power stage model: two switches on a centre-tapped primary, fault injection
// assumes gate drives from the sequencer; drains rise through the winding
`timescale 1ns/100ps
module pps_stage_model (
    // clock
    input  wire logic       clk,
    // drive from the sequencer
    input  wire logic       gate_a,
    input  wire logic       gate_b,
    input  wire logic       drain_a_oe,
    input  wire logic       drain_b_oe,
    // commanded load: 0 normal, 1 soft short, 2 hard short
    input  wire logic [1:0] fault,
    // sensed results back to the sequencer
    output logic            oc_trip,
    output logic            hard_trip,
    output logic            dip_hard,
    output logic            drain_a,
    output logic            drain_b
);
    logic conducting;
    int   on_cyc;
    // a released drain floats up to the supply, never holds its last level
    assign drain_a    = drain_a_oe ? 1'b0 : 1'b1;
    assign drain_b    = drain_b_oe ? 1'b0 : 1'b1;
    assign conducting = (gate_a & drain_a_oe) | (gate_b & drain_b_oe);
    initial begin
        on_cyc    = 0;
        oc_trip   = 1'b0;
        hard_trip = 1'b0;
        dip_hard  = 1'b0;
    end
    always @(posedge clk) begin
        on_cyc = conducting ? on_cyc + 1 : 0;
        // current ramps, so a soft short only trips after a cycle of conduction
        oc_trip   <= #2 (fault != 2'h0) && on_cyc > 1;
        hard_trip <= #2 (fault == 2'h2) && conducting;
        // the dip on the limit pin stays while the short stays
        dip_hard  <= #2 (fault == 2'h2);
    end
endmodule : pps_stage_model

// >>> pps_sequencer_bench.sv
// bench for the push-pull sequencer: scenarios, mode and output checks, verdict
// assumes pps_pkg, pps_sequencer and pps_stage_model are compiled first
`timescale 1ns/100ps
module pps_sequencer_bench;
    localparam int HL = 50;
    localparam int SS = 2;
    localparam int LIMIT = 20000;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        en_above = 1'b0;
    logic        supply_ok = 1'b0;
    logic        temp_hot = 1'b0;
    logic        temp_cool = 1'b1;
    logic        ov_rise = 1'b0;
    logic        ov_clear = 1'b1;
    logic        ext_clk = 1'b0;
    logic [1:0]  fault = 2'h0;
    logic        oc_trip, hard_trip, dip_hard, gate_a, gate_b, prev_a, last_a;
    logic        da_o, da_oe, db_o, db_oe, ss_dis, osc_run, sync_mode, duty_en, spread_en;
    logic [7:0]  strength;
    logic [5:0]  mode;
    logic [15:0] lfsr = 16'h2110;
    int          errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          exp_mode, ext_half = 0, g, low_run = 0, both_hi = 0;
    int          dead_min = 99, retry_min = 99, retry_cnt = 0;
    int          rise_q[$];

    pps_sequencer #(.HARD_LONG_CYC(HL), .SS_STEP_CYC(SS)) pps_sequencer_inst (
        .CLK(clk), .RESET_N(reset_n), .EN_ABOVE(en_above), .SUPPLY_OK(supply_ok),
        .OC_TRIP(oc_trip), .HARD_TRIP(hard_trip), .DIP_HARD(dip_hard),
        .TEMP_HOT(temp_hot), .TEMP_COOL(temp_cool), .OV_RISE(ov_rise),
        .OV_CLEAR(ov_clear), .EXT_CLK(ext_clk), .GATE_A(gate_a), .GATE_B(gate_b),
        .DRAIN_A_O(da_o), .DRAIN_A_OE(da_oe), .DRAIN_B_O(db_o), .DRAIN_B_OE(db_oe),
        .GATE_STRENGTH(strength), .SS_DISCHARGE(ss_dis), .MODE(mode),
        .OSC_RUN(osc_run), .SYNC_MODE(sync_mode), .DUTY_CTRL_EN(duty_en),
        .SPREAD_EN(spread_en));
    pps_stage_model pps_stage_model_inst (
        .clk(clk), .gate_a(gate_a), .gate_b(gate_b), .drain_a_oe(da_oe),
        .drain_b_oe(db_oe), .fault(fault), .oc_trip(oc_trip), .hard_trip(hard_trip),
        .dip_hard(dip_hard), .drain_a(), .drain_b());

    always #12.5 clk = ~clk;

    function automatic logic [15:0] nxt_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt_rand

    task automatic conclude;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wait_mode(input logic [5:0] m, input int lim);
        int n;
        n = 0;
        exp_mode = m;
        while (mode !== m && n < lim) begin
            step(1);
            n++;
        end
        chk("mode", 8'(exp_mode), {2'h0, mode});
    endtask : wait_mode

    task automatic do_reset;
        reset_n = 1'b0;
        en_above = 1'b0;
        supply_ok = 1'b0;
        fault = 2'h0;
        ext_half = 0;
        step(2);
        reset_n = 1'b1;
    endtask : do_reset

    // external source stays idle until the supply is up
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (ext_half > 0 && supply_ok && cycles % ext_half == 0) ext_clk <= #2 ~ext_clk;
        if (cycles == LIMIT) begin
            errors++;
            conclude();
        end
    end

    // gap monitor: a gap ending on the same gate is a retry, otherwise dead time
    always @(posedge clk) begin
        prev_a <= gate_a;
        if (gate_a === 1'b1 && gate_b === 1'b1) both_hi <= both_hi + 1;
        if (gate_a === 1'b1 && prev_a !== 1'b1) rise_q.push_back(cycles);
        if (gate_a !== 1'b1 && gate_b !== 1'b1) begin
            low_run <= low_run + 1;
        end else begin
            if (low_run > 0 && (gate_a === 1'b1) == last_a) begin
                retry_cnt <= retry_cnt + 1;
                if (low_run < retry_min) retry_min <= low_run;
            end else if (low_run > 0 && low_run < dead_min) begin
                dead_min <= low_run;
            end
            low_run <= 0;
            last_a <= (gate_a === 1'b1);
        end
    end

    initial begin
        do_reset();
        chk("mode", 8'(pps_pkg::ST_OFF), {2'h0, mode});
        chk("duty", 8'h01, {7'h0, duty_en});
        supply_ok = 1'b1;
        step(300);
        wait_mode(pps_pkg::ST_OFF, 0);
        lfsr = nxt_rand(lfsr);
        g = 20 + lfsr % 150;
        en_above = 1'b1;
        step(g);
        en_above = 1'b0;
        step(250);
        wait_mode(pps_pkg::ST_OFF, 0);
        supply_ok = 1'b0;
        en_above = 1'b1;
        wait_mode(pps_pkg::ST_WAIT, 220);
        step(20);
        chk("drain oe", 8'h00, {6'h0, da_oe, db_oe});
        supply_ok = 1'b1;
        wait_mode(pps_pkg::ST_SOFT, 10);
        chk("osc run", 8'h01, {7'h0, osc_run});
        retry_cnt = 0;
        fault = 2'h1;
        step(100);
        fault = 2'h0;
        chk("soft retries", 8'h00, 8'(retry_cnt));
        chk("ramp", 8'h01, 8'(strength > 8'h00 && strength < 8'hff));
        wait_mode(pps_pkg::ST_RUN, 256 * SS + 50);
        chk("strength", 8'hff, strength);
        chk("spread on", 8'h01, {7'h0, spread_en});
        chk("drain level", 8'h00, {6'h0, da_o, db_o});
        dead_min = 99;
        step(200);
        chk("dead", 8'h01, 8'(dead_min >= pps_pkg::DEAD_CYC));
        chk("overlap", 8'h00, 8'(both_hi));
        en_above = 1'b0;
        step(g);
        en_above = 1'b1;
        step(250);
        wait_mode(pps_pkg::ST_RUN, 0);
        retry_min = 99;
        retry_cnt = 0;
        fault = 2'h1;
        step(200);
        fault = 2'h0;
        chk("retried", 8'h01, 8'(retry_cnt > 2));
        chk("pause", 8'h01, 8'(retry_min >= pps_pkg::RETRY_CYC));
        temp_cool = 1'b0;
        temp_hot = 1'b1;
        step(3);
        chk("hot gates", 8'h00, {6'h0, gate_a, gate_b});
        temp_hot = 1'b0;
        step(20);
        chk("hot osc", 8'h00, {7'h0, osc_run});
        temp_cool = 1'b1;
        step(10);
        chk("cool osc", 8'h01, {7'h0, osc_run});
        ov_clear = 1'b0;
        ov_rise = 1'b1;
        step(14);
        chk("ov early", 8'h01, {7'h0, osc_run});
        step(16);
        chk("ov stop", 8'h00, {7'h0, osc_run});
        ov_rise = 1'b0;
        step(10);
        chk("ov held", 8'h00, {7'h0, osc_run});
        ov_clear = 1'b1;
        step(10);
        chk("ov clear", 8'h01, {7'h0, osc_run});
        g = 0;
        while (gate_a !== 1'b1 && g < 60) begin
            step(1);
            g++;
        end
        fault = 2'h2;
        step(3);
        chk("hard cut", 8'h00, {6'h0, gate_a, gate_b});
        wait_mode(pps_pkg::ST_DISCH, HL + 20);
        chk("discharge", 8'h01, {7'h0, ss_dis});
        step(1);
        chk("strength", 8'h00, strength);
        fault = 2'h0;
        wait_mode(pps_pkg::ST_SOFT, 20);
        en_above = 1'b0;
        wait_mode(pps_pkg::ST_OFF, 220);
        chk("drain oe", 8'h00, {6'h0, da_oe, db_oe});
        do_reset();
        lfsr = nxt_rand(lfsr);
        ext_half = 4 + lfsr % 4;
        supply_ok = 1'b1;
        step(60);
        chk("sync", 8'h01, {7'h0, sync_mode});
        chk("duty", 8'h00, {7'h0, duty_en});
        en_above = 1'b1;
        wait_mode(pps_pkg::ST_SOFT, 220);
        wait_mode(pps_pkg::ST_RUN, 256 * SS + 50);
        chk("spread", 8'h00, {7'h0, spread_en});
        rise_q.delete();
        step(200);
        chk("period", 8'(4 * ext_half), 8'(rise_q[$] - rise_q[$-1]));
        ext_half = 0;
        wait_mode(pps_pkg::ST_HALT, pps_pkg::EXT_LOSS_CYC + 60);
        lfsr = nxt_rand(lfsr);
        ext_half = 4 + lfsr % 4;
        step(100);
        wait_mode(pps_pkg::ST_HALT, 0);
        chk("halt gates", 8'h00, {6'h0, gate_a, gate_b});
        conclude();
    end
endmodule : pps_sequencer_bench
